// ---- rtl/four_wire_serial_port.sv ----
// Purpose: Four-wire full-duplex serial port, master or slave, on APB.
// Assumes: sys_clk 200 MHz; serial pins are asynchronous to it.
// Notes: Slave pins pass two flops, so slave rate is a fraction of clk.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps

module four_wire_serial_port #(
    parameter int ADDR_W = 8,
    parameter int RATE_W = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt.
    output logic irq,
    // Serial pins.
    input wire logic sckIn,
    input wire logic selectN,
    input wire logic mosiIn,
    input wire logic misoIn,
    output fw_pkg::pin_out_t pinOut
);

    ////////////////////////////////////////////////////////////////////
    // Refuse parameters the decode or divider cannot serve.
    if (ADDR_W < 8 || RATE_W < 1 || RATE_W > 32) begin : g_bad
        $error("four_wire_serial_port: bad ADDR_W or RATE_W");
    end

    typedef struct packed {
        fw_pkg::pin_in_t syncA;
        fw_pkg::pin_in_t syncB;
        fw_pkg::pin_in_t syncC;
        logic portEn;
        logic master_enable_bit;
        logic cpha;
        logic cpol;
        logic [2:0] frame;
        logic [RATE_W-1:0] rate;
        logic [RATE_W-1:0] div;
        logic [7:0] txBuf;
        logic [7:0] rxBuf;
        logic rxFull;
        logic [fw_pkg::ST_W-1:0] stat;
        logic [fw_pkg::ST_W-1:0] mask;
        fw_pkg::phase_t phase;
        logic [7:0] shift;
        logic rxBit;
        logic pend;
        logic [3:0] edgeCnt;
        logic sck;
        logic [31:0] rdat;
    } state_t;

    localparam state_t RST_STATE = '{
        syncA: fw_pkg::PIN_RST,
        syncB: fw_pkg::PIN_RST,
        syncC: fw_pkg::PIN_RST,
        frame: fw_pkg::FRAME_RST,
        phase: fw_pkg::PH_IDLE,
        default: '0
    };

    state_t s_reg;
    state_t s_next;
    fw_pkg::pin_in_t pinsIn;
    logic access;
    logic hit;
    logic startM;
    logic expMsb;
    logic edgeHit;
    logic lead;
    logic smp;
    logic finish;
    logic [7:0] fin;
    logic [7:0] frameMask;
    logic [fw_pkg::ST_W-1:0] setBits;
    logic [31:0] rdMux;

    ////////////////////////////////////////////////////////////////////
    // Bus decode. Zero wait states keep the bus simple; read data is
    // captured in the setup cycle so it leaves a flop.
    assign pinsIn = '{sck: sckIn, selN: selectN, mosi: mosiIn,
                      miso: misoIn};
    assign access = psel && penable;
    assign hit = ((paddr[7:0] == fw_pkg::OFF_CTRL)
              || (paddr[7:0] == fw_pkg::OFF_CFG)
              || (paddr[7:0] == fw_pkg::OFF_RATE)
              || (paddr[7:0] == fw_pkg::OFF_DATA)
              || (paddr[7:0] == fw_pkg::OFF_STAT)
              || (paddr[7:0] == fw_pkg::OFF_MASK))
              && (paddr[ADDR_W-1:0] >> 8) == '0;
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign prdata = s_reg.rdat;
    assign startM = access && pwrite && hit
                 && paddr[7:0] == fw_pkg::OFF_DATA
                 && s_reg.portEn && s_reg.master_enable_bit
                 && s_reg.phase == fw_pkg::PH_IDLE;
    assign expMsb = pwdata[s_reg.frame];
    assign frameMask = 8'hff >> (3'h7 - s_reg.frame);

    // Read multiplexer; reserved bits read as zero.
    always_comb begin
        rdMux = '0;
        case (paddr[7:0])
            fw_pkg::OFF_CTRL: begin
                rdMux[fw_pkg::CTRL_PEN] = s_reg.portEn;
                rdMux[fw_pkg::CTRL_MEN] = s_reg.master_enable_bit;
                rdMux[fw_pkg::CTRL_SEL] = !s_reg.syncB.selN;
                rdMux[fw_pkg::CTRL_BUSY] = s_reg.phase != fw_pkg::PH_IDLE;
                rdMux[fw_pkg::CTRL_RXF] = s_reg.rxFull;
            end
            fw_pkg::OFF_CFG: begin
                rdMux[fw_pkg::CFG_CPHA] = s_reg.cpha;
                rdMux[fw_pkg::CFG_CPOL] = s_reg.cpol;
                rdMux[fw_pkg::CFG_FRAME +: 3] = s_reg.frame;
            end
            fw_pkg::OFF_RATE: rdMux[RATE_W-1:0] = s_reg.rate;
            fw_pkg::OFF_DATA: rdMux[7:0] = s_reg.rxBuf;
            fw_pkg::OFF_STAT: rdMux[fw_pkg::ST_W-1:0] = s_reg.stat;
            fw_pkg::OFF_MASK: rdMux[fw_pkg::ST_W-1:0] = s_reg.mask;
            default: rdMux = '0;
        endcase
        if (!hit) begin
            rdMux = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole port.
    always_comb begin
        s_next = s_reg;
        setBits = '0;
        edgeHit = 1'b0;
        lead = 1'b0;
        smp = 1'b0;
        finish = 1'b0;
        fin = '0;

        // Three flops per pin; only syncB and syncC feed logic.
        s_next.syncA = pinsIn;
        s_next.syncB = s_reg.syncA;
        s_next.syncC = s_reg.syncB;

        if (psel && !penable) begin
            s_next.rdat = rdMux;
        end

        // Reading status or data has side effects at the access edge.
        if (access && !pwrite && hit) begin
            if (paddr[7:0] == fw_pkg::OFF_STAT) begin
                // Clear only what the setup cycle captured, so an event
                // landing between setup and access is not lost.
                s_next.stat = s_reg.stat & ~s_reg.rdat[fw_pkg::ST_W-1:0];
            end
            if (paddr[7:0] == fw_pkg::OFF_DATA) begin
                s_next.rxFull = 1'b0;
            end
        end

        // Register writes.
        if (access && pwrite && hit) begin
            case (paddr[7:0])
                fw_pkg::OFF_CTRL: begin
                    s_next.portEn = pwdata[fw_pkg::CTRL_PEN];
                    s_next.master_enable_bit = pwdata[fw_pkg::CTRL_MEN];
                end
                fw_pkg::OFF_CFG: begin
                    s_next.cpha = pwdata[fw_pkg::CFG_CPHA];
                    s_next.cpol = pwdata[fw_pkg::CFG_CPOL];
                    s_next.frame = pwdata[fw_pkg::CFG_FRAME +: 3];
                end
                fw_pkg::OFF_RATE: s_next.rate = pwdata[RATE_W-1:0];
                fw_pkg::OFF_MASK: s_next.mask = pwdata[fw_pkg::ST_W-1:0];
                fw_pkg::OFF_DATA: begin
                    if (s_reg.phase != fw_pkg::PH_IDLE) begin
                        setBits[fw_pkg::ST_WRITE_COLLISION_FLAG] = 1'b1;
                    end else begin
                        s_next.txBuf = pwdata[7:0];
                    end
                end
                default: s_next.portEn = s_reg.portEn;
            endcase
        end

        // Start a master frame, MSB aligned to bit 7.
        if (startM) begin
            s_next.phase = fw_pkg::PH_MASTER;
            s_next.shift = pwdata[7:0] << (3'h7 - s_reg.frame);
            s_next.edgeCnt = '0;
            s_next.div = '0;
            s_next.pend = 1'b0;
        end

        case (s_reg.phase)
            fw_pkg::PH_IDLE: begin
                s_next.sck = s_reg.cpol;
                // A falling select loads whatever software left queued.
                if (s_reg.portEn && !s_reg.master_enable_bit && s_reg.syncC.selN
                    && !s_reg.syncB.selN) begin
                    s_next.phase = fw_pkg::PH_SLAVE;
                    s_next.shift = s_reg.txBuf << (3'h7 - s_reg.frame);
                    s_next.pend = 1'b0;
                end
            end
            fw_pkg::PH_MASTER: begin
                // Half period is rate+1 clocks. MISO comes in through two
                // flops, so a RATE below 2 can miss read bits.
                if (s_reg.div == s_reg.rate) begin
                    s_next.div = '0;
                    s_next.sck = !s_reg.sck;
                    s_next.edgeCnt = s_reg.edgeCnt + 4'h1;
                    edgeHit = 1'b1;
                    lead = !s_reg.edgeCnt[0];
                    smp = s_reg.syncB.miso;
                    finish = s_reg.edgeCnt == {s_reg.frame, 1'b1};
                end else begin
                    s_next.div = s_reg.div + 1'b1;
                end
            end
            fw_pkg::PH_SLAVE: begin
                // Frame ends only when the far master lifts select.
                if (s_reg.syncB.selN) begin
                    finish = 1'b1;
                end else if (s_reg.syncB.sck != s_reg.syncC.sck) begin
                    // Edges take three clocks to surface here, which is
                    // what bounds the slave bit rate.
                    edgeHit = 1'b1;
                    lead = s_reg.syncB.sck != s_reg.cpol;
                    smp = s_reg.syncB.mosi;
                end
            end
            default: s_next.phase = fw_pkg::PH_IDLE;
        endcase

        // Sample on one edge, shift on the other, chosen by phase.
        if (edgeHit) begin
            if (lead != s_reg.cpha) begin
                s_next.rxBit = smp;
                s_next.pend = 1'b1;
            end else if (s_reg.pend) begin
                s_next.shift = {s_reg.shift[6:0], s_reg.rxBit};
                s_next.pend = 1'b0;
            end
        end

        // Frame complete: a full receive buffer keeps its old byte.
        if (finish) begin
            fin = s_next.pend ? {s_next.shift[6:0], s_next.rxBit}
                              : s_next.shift;
            s_next.shift = fin;
            s_next.pend = 1'b0;
            s_next.phase = fw_pkg::PH_IDLE;
            s_next.sck = s_reg.cpol;
            setBits[fw_pkg::ST_DONE] = 1'b1;
            if (s_next.rxFull) begin
                setBits[fw_pkg::ST_OVR] = 1'b1;
            end else begin
                s_next.rxBuf = fin & frameMask;
                s_next.rxFull = 1'b1;
            end
        end

        // Another master pulled select low: take the port off line.
        if (s_reg.portEn && s_reg.master_enable_bit && !s_reg.syncB.selN) begin
            s_next.master_enable_bit = 1'b0;
            s_next.portEn = 1'b0;
            setBits[fw_pkg::ST_MODE_FAULT_FLAG] = 1'b1;
        end

        // Disabling the port aborts a frame without a flag; setting master enable during a slave frame aborts it, and the low select then sets the mode fault flag.
        if (!s_next.portEn || (s_reg.phase == fw_pkg::PH_SLAVE
                               && s_next.master_enable_bit)) begin
            s_next.phase = fw_pkg::PH_IDLE;
            s_next.pend = 1'b0;
        end

        // Hardware sets win over a read that clears in the same cycle.
        s_next.stat = s_next.stat | setBits;
    end

    ////////////////////////////////////////////////////////////////////
    // The single state register.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers and the interrupt.
    assign pinOut.sckOut = s_reg.sck;
    assign pinOut.sckOe = s_reg.portEn && s_reg.master_enable_bit;
    assign pinOut.mosiOut = s_reg.shift[7];
    assign pinOut.mosiOe = s_reg.portEn && s_reg.master_enable_bit;
    assign pinOut.misoOut = s_reg.shift[7];
    assign pinOut.misoOe = s_reg.portEn && !s_reg.master_enable_bit
                        && !s_reg.syncB.selN;
    assign irq = |(s_reg.stat & s_reg.mask);

    ////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_miso_release: assert property (
        (!s_reg.portEn || s_reg.master_enable_bit || s_reg.syncB.selN)
        |-> !pinOut.misoOe)
        else $error("MISO driven while not a selected slave");

    chk_master_pins: assert property (
        s_reg.portEn && s_reg.master_enable_bit
        |-> pinOut.sckOe && pinOut.mosiOe && !pinOut.misoOe)
        else $error("master role pins wrong");

    chk_mode_fault: assert property (
        s_reg.portEn && s_reg.master_enable_bit && !s_reg.syncB.selN
        |=> !s_reg.master_enable_bit && !s_reg.portEn
            && s_reg.stat[fw_pkg::ST_MODE_FAULT_FLAG])
        else $error("mode fault did not take port off line");

    chk_write_collide: assert property (
        access && pwrite && paddr[7:0] == fw_pkg::OFF_DATA
        && s_reg.phase == fw_pkg::PH_MASTER
        && s_reg.syncB.selN
        |=> s_reg.stat[fw_pkg::ST_WRITE_COLLISION_FLAG]
            && s_reg.phase == fw_pkg::PH_MASTER)
        else $error("busy write not flagged or transfer broken");

    chk_master_start: assert property (
        startM && s_reg.syncB.selN |=> s_reg.phase == fw_pkg::PH_MASTER)
        else $error("data write did not start master frame");

    chk_msb_first: assert property (
        startM && s_reg.syncB.selN |=> pinOut.mosiOut == $past(expMsb))
        else $error("first MOSI bit is not the frame MSB");

    chk_sck_idle: assert property (
        s_reg.phase == fw_pkg::PH_IDLE ##1 s_reg.phase == fw_pkg::PH_IDLE
        |-> pinOut.sckOut == $past(s_reg.cpol))
        else $error("SCK not at idle level");

    chk_master_done: assert property (
        s_reg.phase == fw_pkg::PH_MASTER && s_reg.div == s_reg.rate
        && s_reg.edgeCnt == {s_reg.frame, 1'b1}
        && s_reg.portEn && s_reg.syncB.selN
        |=> s_reg.phase == fw_pkg::PH_IDLE
            && s_reg.stat[fw_pkg::ST_DONE])
        else $error("master frame length wrong");

    chk_slave_sync: assert property (
        s_reg.portEn && !s_reg.master_enable_bit && s_reg.phase == fw_pkg::PH_IDLE
        && $fell(selectN) ##1 !selectN ##1 !selectN
        |=> s_reg.phase == fw_pkg::PH_SLAVE)
        else $error("slave select not seen three clocks later");

endmodule

// ---- shared/fw_pkg.sv ----
// Purpose: Shared constants and types of the four-wire serial port.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes: Offsets are used by name only; field positions by name in the RTL, as numbers in the bench.
package fw_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_RATE = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;

    // Control register bits; the upper three are read only.
    localparam int CTRL_PEN = 0;
    localparam int CTRL_MEN = 1;
    localparam int CTRL_SEL = 2;
    localparam int CTRL_BUSY = 3;
    localparam int CTRL_RXF = 4;

    // Configuration register fields.
    localparam int CFG_CPHA = 7;
    localparam int CFG_CPOL = 6;
    localparam int CFG_FRAME = 0;
    localparam logic [2:0] FRAME_RST = 3'h7;
    localparam logic [2:0] FRAME_MAX = 3'h7;

    // Status and mask bits.
    localparam int ST_W = 4;
    localparam int ST_DONE = 0;
    localparam int ST_WRITE_COLLISION_FLAG = 1;
    localparam int ST_MODE_FAULT_FLAG = 2;
    localparam int ST_OVR = 3;

    ////////////////////////////////////////////////////////////////////
    // Transfer phase.
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_MASTER = 2'b01,
        PH_SLAVE = 2'b10
    } phase_t;

    // Serial pins seen from outside, and their idle levels.
    typedef struct packed {
        logic sck;
        logic selN;
        logic mosi;
        logic miso;
    } pin_in_t;
    localparam pin_in_t PIN_RST = 4'h4;

    // Serial pin drivers with their output enables.
    typedef struct packed {
        logic sckOut;
        logic sckOe;
        logic mosiOut;
        logic mosiOe;
        logic misoOut;
        logic misoOe;
    } pin_out_t;

endpackage

// ---- tb/four_wire_serial_port_tb.sv ----
// Purpose: Self-checking bench of the four-wire serial port.
// Assumes: Far side is a behavioural slave; bench acts as bus master.
// Notes: Expected values are worked out here from the transfer rules.
`timescale 1ns/10ps
module four_wire_serial_port_tb;
    ////////////////////////////////////////////////////////////////////
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    fw_pkg::pin_out_t pinOut;
    logic tbSck = 1'b0;
    logic tbSelN = 1'b1;
    logic tbMosi = 1'b0;
    logic pSel = 1'b0;
    logic [7:0] pTx = 8'h00;
    logic [7:0] pRx;
    logic pMiso;
    logic sckPrev = 1'b0;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int n_compared = 0;
    int rate = 0;
    int sckGap = 0;
    // Each line is resolved from whoever enables a driver on it.
    wire sckLine = pinOut.sckOe ? pinOut.sckOut : tbSck;
    wire mosiLine = pinOut.mosiOe ? pinOut.mosiOut : tbMosi;
    wire misoLine = pinOut.misoOe ? pinOut.misoOut : pMiso;

    always #2.5 sys_clk = ~sys_clk;

    four_wire_serial_port DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .sckIn(sckLine), .selectN(tbSelN), .mosiIn(mosiLine),
        .misoIn(misoLine), .pinOut(pinOut)
    );

    serial_far_end FAR (
        .sck(sckLine), .mosi(mosiLine), .miso(pMiso), .sel(pSel),
        .txByte(pTx), .rxByte(pRx)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One bus transfer; entered just after a rising edge, leaves one idle.
    task automatic apb(input logic [7:0] a, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rdv,
                       output logic er);
        int k;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, rd, err);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, rd, err);
        check(what, rd, exp);
    endtask

    // A hung transfer would otherwise stall the run forever.
    task automatic wait_irq();
        int k;
        for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge sys_clk);
        if (irq !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    // Bench as master at 160 ns a bit, off the system clock grid.
    task automatic slave_frame(input logic [7:0] mo,
                               output logic [7:0] mi);
        int b;
        #2.3;
        tbSelN = 1'b0;
        for (b = 7; b >= 0; b--) begin
            tbMosi = mo[b];
            #80;
            mi = {mi[6:0], misoLine};
            tbSck = 1'b1;
            #80;
            tbSck = 1'b0;
        end
        #80;
        tbMosi = ~tbMosi;
        tbSelN = 1'b1;
    endtask

    // A half period shorter than programmed would break the rate limit.
    always @(posedge sys_clk) begin
        if (!pinOut.sckOe) begin
            sckGap <= 0;
        end else if (pinOut.sckOut !== sckPrev) begin
            if (sckGap != 0) begin
                check("sck gap", 32'(sckGap >= rate + 1), 1);
            end
            sckGap <= 1;
        end else if (sckGap != 0) begin
            sckGap <= sckGap + 1;
        end
        sckPrev <= pinOut.sckOut;
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence: reset, master frames of every size, fault, slave.
    initial begin
        int f;
        int unsigned seed;
        logic [7:0] tx;
        logic [7:0] pb;
        logic [7:0] m;
        logic [7:0] got;
        seed = $urandom(20);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdchk("cfg reset", fw_pkg::OFF_CFG, 32'h7);
        rdchk("ctrl reset", fw_pkg::OFF_CTRL, 32'h0);
        apb(8'h40, 1'b0, 32'h0, rd, err);
        check("unmapped", {31'h0, err}, 32'h1);
        wr(fw_pkg::OFF_MASK, 32'h1);
        wr(fw_pkg::OFF_CTRL, 32'h3);
        for (f = 0; f < 8; f++) begin
            tx = 8'($urandom);
            pb = 8'($urandom);
            m = 8'((9'h1 << (f + 1)) - 9'h1);
            // Synchronised MISO needs a half period of three clocks.
            rate = 2 + $urandom_range(3);
            pTx <= pb;
            wr(fw_pkg::OFF_RATE, 32'(rate));
            wr(fw_pkg::OFF_CFG, 32'(f));
            pSel <= 1'b1;
            wr(fw_pkg::OFF_DATA, {24'h0, tx});
            if (f == 3) wr(fw_pkg::OFF_DATA, 32'h5a);
            wait_irq();
            rdchk("status", fw_pkg::OFF_STAT,
                  (f == 3) ? 32'h3 : 32'h1);
            check("irq clear", {31'h0, irq}, 32'h0);
            rdchk("master rx", fw_pkg::OFF_DATA,
                  32'(pb >> (7 - f)));
            check("far rx", {24'h0, pRx},
                  {24'h0, tx & m});
            pSel <= 1'b0;
        end
        // Two frames left unread: the second overruns, its byte is lost.
        pTx <= 8'h96;
        @(posedge sys_clk);
        pSel <= 1'b1;
        wr(fw_pkg::OFF_DATA, 32'h3c);
        wait_irq();
        rdchk("first done", fw_pkg::OFF_STAT, 32'h1);
        wr(fw_pkg::OFF_DATA, 32'hc3);
        wait_irq();
        rdchk("overrun", fw_pkg::OFF_STAT, 32'h9);
        rdchk("kept rx", fw_pkg::OFF_DATA, 32'h96);
        pSel <= 1'b0;
        wr(fw_pkg::OFF_CTRL, 32'h3);
        tbSelN <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rdchk("ctrl fault", fw_pkg::OFF_CTRL, 32'h4);
        rdchk("fault flag", fw_pkg::OFF_STAT, 32'h4);
        check("oe off", {29'h0, pinOut.sckOe, pinOut.mosiOe,
              pinOut.misoOe}, 32'h0);
        tbSelN <= 1'b1;
        repeat (4) @(posedge sys_clk);
        tx = 8'($urandom);
        pb = 8'($urandom);
        wr(fw_pkg::OFF_CTRL, 32'h1);
        wr(fw_pkg::OFF_CFG, 32'h7);
        wr(fw_pkg::OFF_DATA, {24'h0, tx});
        check("miso idle", {31'h0, pinOut.misoOe}, 32'h0);
        slave_frame(pb, got);
        repeat (10) @(posedge sys_clk);
        check("slave miso", {24'h0, got},
              {24'h0, tx});
        rdchk("slave done", fw_pkg::OFF_STAT, 32'h1);
        rdchk("slave rx", fw_pkg::OFF_DATA, {24'h0, pb});
        check("miso after", {31'h0, pinOut.misoOe}, 32'h0);
        tally_and_finish();
    end
endmodule

// ---- tb/serial_far_end.sv ----
// Purpose: Behavioural slave on the far side of the serial link.
// Assumes: Clock idles low, data is sampled on the rising clock edge.
// Notes: An unselected slave shows the inverse of its last bit.
`timescale 1ns/10ps
module serial_far_end (
    // Serial lines.
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Bench side.
    input wire logic sel,
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] shiftReg = 8'h00;
    logic lastBit = 1'b0;

    // Load on select, so the first bit is ready before any clock edge.
    always @(posedge sel) begin
        shiftReg = txByte;
        rxByte = 8'h00;
    end

    // Sample on the leading edge; the first bit seen is the MSB.
    always @(posedge sck) begin
        if (sel) begin
            rxByte = {rxByte[6:0], mosi};
        end
    end

    // Shift on the trailing edge, timed only by the master's clock.
    always @(negedge sck) begin
        if (sel) begin
            shiftReg = {shiftReg[6:0], 1'b0};
        end
    end

    // Remember the last bit so a released line never looks held.
    always @(negedge sel) begin
        lastBit = shiftReg[7];
    end

    assign miso = sel ? shiftReg[7] : ~lastBit;
endmodule
